// ===== verilog/acc_pkg.sv
// Package for the converter channel, calibration and address control block.
// Assumes a 32-bit APB register bus and a 40 MHz system clock.
`default_nettype none

package acc_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_PIN_FUNC    = 8'h04;
	localparam logic [7:0] OFS_DIRECTION   = 8'h08;
	localparam logic [7:0] OFS_OUT_LEVEL   = 8'h0C;
	localparam logic [7:0] OFS_DRIVER_TYPE = 8'h10;
	localparam logic [7:0] OFS_READBACK    = 8'h14;
	localparam logic [7:0] OFS_RESULT      = 8'h18;
	localparam logic [7:0] OFS_TARGET_ADDR = 8'h1C;
	localparam logic [7:0] OFS_THRESHOLD   = 8'h20;
	localparam logic [7:0] OFS_ALERT_FLAGS = 8'h24;
	localparam logic [7:0] OFS_CRC         = 8'h28;

	// ----------------------------------------------------------------
	// Control, threshold and result register field positions
	// ----------------------------------------------------------------
	localparam int CTRL_CAL     = 0;
	localparam int CTRL_SEQ_RUN = 1;
	localparam int CTRL_HS_EN   = 2;
	localparam int CTRL_SOFT_RST = 3;
	localparam int CTRL_MODE_LO = 4;
	localparam int CTRL_CHAN_LO = 8;
	localparam int THR_LO_LO    = 0;
	localparam int THR_HI_LO    = 16;
	localparam int RES_CHAN_LO  = 12;
	localparam int AVG_LO       = 16;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [7:0]  PIN_FUNC_RST  = 8'h00;
	localparam logic [11:0] THR_HI_RST    = 12'hFFF;
	localparam logic [11:0] THR_LO_RST    = 12'h000;
	localparam logic [7:0]  CRC_POLY      = 8'h07;
	localparam logic [7:0]  CRC_INIT      = 8'hFF;
	localparam logic [3:0]  SWITCH_FALLS  = 4'h9;
	localparam logic [6:0]  ADDR_UPPER_TOP = 7'h17;
	localparam logic [6:0]  ADDR_LOWER_BASE = 7'h10;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	typedef enum logic [1:0] {
		ACC_MODE_MANUAL,
		ACC_MODE_AUTONOMOUS,
		ACC_MODE_TURBO
	} acc_mode_t;

endpackage : acc_pkg

`default_nettype wire

// ===== verilog/acc_control.sv
// Channel function, pin driver, result, calibration and bus address control.
// Assumes an APB master, a SAR converter core that answers conv_start with
// conv_done and a 12-bit code, and serial-bus inputs already synchronous.
//
// Operation
// - Reset puts all eight channels into analog-input function.
// - Sample switch closed in acquisition, opened at ninth falling SCL of read in manual mode.
// - Function select bit per channel picks analog input or digital I/O.
// - Direction bit per digital channel sets it input or output.
// - Readback register returns every channel pin level regardless of function.
// - Digital output channels drive the written output level bit.
// - Driver type bit picks open-drain or push-pull per output channel.
// - Results are unsigned straight-binary 12-bit codes.
// - Codes run from 000 through 800 at mid-scale to FFF.
// - Host sets calibration bit; device clears it when calibration completes.
// - Target address decided once at power-up from strap pin level.
// - Address kept until power-up, device reset or programmed new address.
// - Strap decode gives 17h down to 14h, or 10h up to 13h.
// - APB register transfers are folded into an 8-bit CRC check value.
// - Manual mode plus autonomous and turbo monitoring modes.
// - Alert output signals any channel crossing high or low threshold in autonomous and turbo modes.
// - Averaging filter produces a 16-bit result.
// - Standard, fast-mode plus and high-speed bus modes supported.
// - Only standard and fast speeds until host enables high speed.
`default_nettype none

module acc_control #(
	parameter int NUM_CH   = 8,
	parameter int AVG_LOG2 = 4
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Channel pins
	input  wire logic [7:0]  channel_pin_in,
	output logic [7:0]       channel_pin_out,
	output logic [7:0]       channel_pin_oe,
	// Serial bus side
	input  wire logic        scl,
	input  wire logic        bus_read_active,
	input  wire logic [7:0]  addr_byte,
	input  wire logic        addr_byte_valid,
	output logic             addr_ack,
	output logic             high_speed_enable,
	input  wire logic [2:0]  strap_level,
	// Converter core
	output logic             sample_switch,
	output logic             conv_start,
	output logic [2:0]       conv_chan,
	input  wire logic        conv_done,
	input  wire logic [11:0] conv_code,
	output logic             cal_start,
	input  wire logic        cal_done,
	output logic             alert
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (NUM_CH != 8) begin : g_bad_ch
		$error("acc_control supports exactly eight channels");
	end
	if (AVG_LOG2 != 4) begin : g_bad_avg
		$error("acc_control averaging needs sixteen samples for a 16-bit sum");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        cal;
		logic        seq_run;
		logic        hs_en;
		logic [1:0]  mode;
		logic [2:0]  man_chan;
		logic [7:0]  pin_func;
		logic [7:0]  direction;
		logic [7:0]  out_level;
		logic [7:0]  driver_type;
		logic [7:0]  pin_level;
		logic [7:0]  pin_out;
		logic [7:0]  pin_oe;
		logic [6:0]  tgt_addr;
		logic        strap_done;
		logic        addr_ack;
		logic [11:0] thr_hi;
		logic [11:0] thr_lo;
		logic [11:0] result;
		logic [2:0]  res_chan;
		logic [15:0] avg_result;
		logic [15:0] avg_acc;
		logic [3:0]  avg_cnt;
		logic [7:0]  alert_flags;
		logic        alert;
		logic [7:0]  crc;
		logic        scl_q;
		logic [3:0]  fall_cnt;
		logic        switch_closed;
		logic        conv_busy;
		logic        conv_start;
		logic [2:0]  conv_chan;
		logic        cal_start;
		logic        cal_busy;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} acc_state_t;

	acc_state_t st;
	acc_state_t next_st;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Strap level to target address: low indices use the upper resistor
	function automatic logic [6:0] strap_decode(input logic [2:0] lvl);
		logic [6:0] a;
		a = '0;
		if (lvl[2] == 1'b0) begin
			a = acc_pkg::ADDR_UPPER_TOP - {5'h00, lvl[1:0]};
		end else begin
			a = acc_pkg::ADDR_LOWER_BASE + {5'h00, lvl[1:0]};
		end
		return a;
	endfunction : strap_decode

	// CRC-8 over a 32-bit word, most significant bit first
	function automatic logic [7:0] crc8_word(input logic [31:0] w);
		logic [7:0] c;
		c = acc_pkg::CRC_INIT;
		for (int i = 31; i >= 0; i--) begin
			if (c[7] ^ w[i]) begin
				c = {c[6:0], 1'b0} ^ acc_pkg::CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction : crc8_word

	// Reset image of the whole state
	function automatic acc_state_t reset_state();
		acc_state_t r;
		r = '0;
		r.pin_func = acc_pkg::PIN_FUNC_RST;
		r.mode     = 2'(acc_pkg::ACC_MODE_MANUAL);
		r.thr_hi   = acc_pkg::THR_HI_RST;
		r.thr_lo   = acc_pkg::THR_LO_RST;
		r.crc      = acc_pkg::CRC_INIT;
		r.switch_closed = 1'b1;
		return r;
	endfunction : reset_state

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic        acc_setup;
	logic        acc_commit;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        scl_fall;
	logic        cal_ok;
	logic        soft_rst;
	logic        start_now;
	logic [2:0]  start_chan;

	// Register bus decode, pin drivers, converter sequencing and calibration
	always_comb begin
		next_st    = st;
		acc_setup  = psel && penable && !st.pready;
		acc_commit = psel && penable && st.pready;
		rd_word    = acc_pkg::UNMAPPED_DATA;
		rd_hit     = 1'b1;
		soft_rst   = 1'b0;
		start_now  = 1'b0;
		start_chan = st.man_chan;
		scl_fall   = st.scl_q && !scl;
		cal_ok     = 1'b0;

		// Read mux of the mapped registers
		case (paddr)
			acc_pkg::OFS_CTRL: begin
				rd_word[acc_pkg::CTRL_CAL]     = st.cal;
				rd_word[acc_pkg::CTRL_SEQ_RUN] = st.seq_run;
				rd_word[acc_pkg::CTRL_HS_EN]   = st.hs_en;
				rd_word[acc_pkg::CTRL_MODE_LO +: 2] = st.mode;
				rd_word[acc_pkg::CTRL_CHAN_LO +: 3] = st.man_chan;
			end
			acc_pkg::OFS_PIN_FUNC:    rd_word[7:0] = st.pin_func;
			acc_pkg::OFS_DIRECTION:   rd_word[7:0] = st.direction;
			acc_pkg::OFS_OUT_LEVEL:   rd_word[7:0] = st.out_level;
			acc_pkg::OFS_DRIVER_TYPE: rd_word[7:0] = st.driver_type;
			acc_pkg::OFS_READBACK:    rd_word[7:0] = st.pin_level;
			acc_pkg::OFS_RESULT: begin
				rd_word[11:0] = st.result;
				rd_word[acc_pkg::RES_CHAN_LO +: 3] = st.res_chan;
				rd_word[acc_pkg::AVG_LO +: 16] = st.avg_result;
			end
			acc_pkg::OFS_TARGET_ADDR: rd_word[6:0] = st.tgt_addr;
			acc_pkg::OFS_THRESHOLD: begin
				rd_word[acc_pkg::THR_LO_LO +: 12] = st.thr_lo;
				rd_word[acc_pkg::THR_HI_LO +: 12] = st.thr_hi;
			end
			acc_pkg::OFS_ALERT_FLAGS: rd_word[7:0] = st.alert_flags;
			acc_pkg::OFS_CRC:         rd_word[7:0] = st.crc;
			default:                  rd_hit = 1'b0;
		endcase

		// APB answer: access phase held one cycle, answer on the second
		next_st.pready = acc_setup;
		if (acc_setup) begin
			next_st.prdata  = pwrite ? acc_pkg::UNMAPPED_DATA : rd_word;
			next_st.pslverr = !rd_hit;
		end
		if (acc_commit) begin
			next_st.pslverr = 1'b0;
			// Each transfer word is folded into the running check value
			next_st.crc = crc8_word(pwrite ? pwdata : st.prdata) ^ st.crc;
		end

		// Register writes take effect at the edge that samples pready
		if (acc_commit && pwrite && rd_hit) begin
			case (paddr)
				acc_pkg::OFS_CTRL: begin
					next_st.seq_run  = pwdata[acc_pkg::CTRL_SEQ_RUN];
					next_st.hs_en    = pwdata[acc_pkg::CTRL_HS_EN];
					next_st.mode     = pwdata[acc_pkg::CTRL_MODE_LO +: 2];
					next_st.man_chan = pwdata[acc_pkg::CTRL_CHAN_LO +: 3];
					soft_rst         = pwdata[acc_pkg::CTRL_SOFT_RST];
					// Calibration is refused while the sequencer runs
					cal_ok = pwdata[acc_pkg::CTRL_CAL] && !st.seq_run
						&& !pwdata[acc_pkg::CTRL_SEQ_RUN];
					if (cal_ok && !st.cal) begin
						next_st.cal = 1'b1;
					end
				end
				acc_pkg::OFS_PIN_FUNC:    next_st.pin_func    = pwdata[7:0];
				acc_pkg::OFS_DIRECTION:   next_st.direction   = pwdata[7:0];
				acc_pkg::OFS_OUT_LEVEL:   next_st.out_level   = pwdata[7:0];
				acc_pkg::OFS_DRIVER_TYPE: next_st.driver_type = pwdata[7:0];
				acc_pkg::OFS_TARGET_ADDR: next_st.tgt_addr    = pwdata[6:0];
				acc_pkg::OFS_THRESHOLD: begin
					next_st.thr_lo = pwdata[acc_pkg::THR_LO_LO +: 12];
					next_st.thr_hi = pwdata[acc_pkg::THR_HI_LO +: 12];
				end
				acc_pkg::OFS_ALERT_FLAGS: begin
					// Write one to clear; a crossing in the same cycle is kept below
					next_st.alert_flags = st.alert_flags & ~pwdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// Strap caught once after reset release
		if (!st.strap_done) begin
			next_st.tgt_addr   = strap_decode(strap_level);
			next_st.strap_done = 1'b1;
		end

		// Address byte match against the held target address
		next_st.addr_ack = addr_byte_valid && (addr_byte[7:1] == st.tgt_addr);

		// Pin readback and drivers per channel
		next_st.pin_level = channel_pin_in;
		for (int i = 0; i < NUM_CH; i++) begin
			next_st.pin_out[i] = 1'b0;
			next_st.pin_oe[i]  = 1'b0;
			if (next_st.pin_func[i] && next_st.direction[i]) begin
				if (next_st.driver_type[i]) begin
					next_st.pin_out[i] = next_st.out_level[i];
					next_st.pin_oe[i]  = 1'b1;
				end else begin
					next_st.pin_oe[i]  = !next_st.out_level[i];
				end
			end
		end

		// Count falling SCL edges of a read access
		next_st.scl_q      = scl;
		next_st.conv_start = 1'b0;
		next_st.cal_start  = 1'b0;
		if (!bus_read_active) begin
			next_st.fall_cnt = '0;
		end else if (scl_fall && st.fall_cnt != acc_pkg::SWITCH_FALLS) begin
			next_st.fall_cnt = st.fall_cnt + 4'h1;
		end

		// Manual mode: ninth fall opens the switch and starts a conversion
		if (st.mode == 2'(acc_pkg::ACC_MODE_MANUAL)) begin
			if (bus_read_active && scl_fall && st.fall_cnt == acc_pkg::SWITCH_FALLS - 4'h1
				&& !st.conv_busy && !st.cal_busy) begin
				start_now = 1'b1;
			end
		end else if (st.seq_run && !st.conv_busy && !st.cal_busy) begin
			// Autonomous and turbo modes convert with no bus traffic
			start_now  = 1'b1;
			start_chan = st.conv_chan + 3'h1;
		end
		if (start_now) begin
			next_st.switch_closed = 1'b0;
			next_st.conv_busy  = 1'b1;
			next_st.conv_start = 1'b1;
			next_st.conv_chan  = start_chan;
		end

		// Conversion result, averaging and threshold watch
		if (st.conv_busy && conv_done) begin
			next_st.conv_busy = 1'b0;
			next_st.switch_closed = 1'b1;
			next_st.result    = conv_code;
			next_st.res_chan  = st.conv_chan;
			if (st.avg_cnt == 4'hF) begin
				next_st.avg_result = st.avg_acc + {4'h0, conv_code};
				next_st.avg_acc    = '0;
			end else begin
				next_st.avg_acc = st.avg_acc + {4'h0, conv_code};
			end
			next_st.avg_cnt = st.avg_cnt + 4'h1;
			if (st.mode != 2'(acc_pkg::ACC_MODE_MANUAL)
				&& (conv_code > st.thr_hi || conv_code < st.thr_lo)) begin
				next_st.alert_flags[st.conv_chan] = 1'b1;
			end
		end
		next_st.alert = |next_st.alert_flags;

		// Offset calibration handshake with the converter core
		if (st.cal && !st.cal_busy && !st.conv_busy && !start_now) begin // Never alongside a conversion start
			next_st.cal_busy  = 1'b1;
			next_st.cal_start = 1'b1;
		end else if (st.cal_busy && cal_done) begin
			next_st.cal_busy = 1'b0;
			next_st.cal      = 1'b0;
		end

		// Device reset restores defaults and decides the address again
		if (soft_rst) begin
			next_st = reset_state();
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Synchronous reset to the defaults
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= reset_state();
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output is a field of the state register
	assign pready            = st.pready;
	assign prdata            = st.prdata;
	assign pslverr           = st.pslverr;
	assign channel_pin_out   = st.pin_out;
	assign channel_pin_oe    = st.pin_oe;
	assign addr_ack          = st.addr_ack;
	assign high_speed_enable = st.hs_en;
	assign sample_switch     = st.switch_closed;
	assign conv_start        = st.conv_start;
	assign conv_chan         = st.conv_chan;
	assign cal_start         = st.cal_start;
	assign alert             = st.alert;

endmodule : acc_control

`default_nettype wire

// ===== verification/acc_control_properties.sv
// Port checker for the channel, calibration and address control block.
// Assumes one clock domain and a bind onto acc_control.
`default_nettype none

module acc_props (
	input wire logic	clk,
	input wire logic	rstn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic	pready,
	input wire logic [31:0]	prdata,
	input wire logic	pslverr,
	input wire logic [7:0]	channel_pin_oe,
	input wire logic	scl,
	input wire logic	bus_read_active,
	input wire logic	addr_byte_valid,
	input wire logic	addr_ack,
	input wire logic	high_speed_enable,
	input wire logic	sample_switch,
	input wire logic	conv_start,
	input wire logic	conv_done,
	input wire logic	cal_start
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]	falls;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------------------------------
	// Helper logic and sequences
	// ----------------------------------------------------------------
	// Falling scl edges seen so far in the current read access
	always_ff @(posedge clk) begin
		if (!rstn || !bus_read_active)
			falls <= 4'h0;
		else if ($fell(scl))
			falls <= falls + 4'h1;
	end

	sequence s_ninth_fall;
		bus_read_active && $fell(scl) && falls == 4'h8;
	endsequence

	sequence s_cal_write;
		psel && penable && pready && pwrite && paddr == acc_pkg::OFS_CTRL &&
			pwdata[acc_pkg::CTRL_CAL] && !pwdata[acc_pkg::CTRL_SEQ_RUN] && !pwdata[acc_pkg::CTRL_SOFT_RST];
	endsequence

	a_reset_idle: assert property ($rose(rstn) |-> channel_pin_oe == 8'h00 && sample_switch)
		else $error("pins or sample switch not idle after reset");
	a_speed_default: assert property ($rose(rstn) |-> !high_speed_enable)
		else $error("high speed enabled after reset");
	a_apb_wait: assert property ($rose(psel && penable) |=> pready)
		else $error("apb answer not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_unmapped_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
		else $error("refused access returned data");
	a_switch_ninth: assert property (s_ninth_fall |=> !sample_switch && conv_start)
		else $error("switch not opened on ninth falling scl");
	a_switch_held: assert property (!sample_switch && !conv_done |=> !sample_switch)
		else $error("switch closed before conversion end");
	a_cal_launch: assert property (s_cal_write |-> ##2 cal_start ##1 !cal_start)
		else $error("calibration start pulse missing");
	a_ack_follows: assert property (addr_ack |-> $past(addr_byte_valid))
		else $error("acknowledge without address byte");
endmodule : acc_props

bind acc_control acc_props i_acc_props (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .prdata, .pslverr, .channel_pin_oe, .scl, .bus_read_active, .addr_byte_valid,
	.addr_ack, .high_speed_enable, .sample_switch, .conv_start, .conv_done, .cal_start);

`default_nettype wire

// ===== verification/acc_bus_host.sv
// Serial host model: frames read accesses on scl and sends address bytes.
// Assumes the bench clock; scl rests high outside frames.
`default_nettype none

module acc_bus_host (
	input wire logic	clk,
	output logic	scl,
	output logic	bus_read_active,
	output logic [7:0]	addr_byte,
	output logic	addr_byte_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		bus_read_active = 1'b0;
		addr_byte = 8'h00;
		addr_byte_valid = 1'b0;
	end

	// ----------------------------------------------------------------
	// Frames
	// ----------------------------------------------------------------
	// Read access with n falling scl edges
	task automatic read_frame(input int n);
		bus_read_active <= 1'b1;
		repeat (n) begin
			@(posedge clk) scl <= 1'b0;
			repeat (2) @(posedge clk);
			scl <= 1'b1;
			repeat (2) @(posedge clk);
		end
		bus_read_active <= 1'b0;
		@(posedge clk);
	endtask : read_frame

	// One received address byte
	task automatic send_addr(input logic [7:0] b);
		addr_byte <= b;
		addr_byte_valid <= 1'b1;
		@(posedge clk) addr_byte_valid <= 1'b0;
		addr_byte <= ~b; // Released byte shows no stale value
	endtask : send_addr
endmodule : acc_bus_host

`default_nettype wire

// ===== verification/tb_adc_channel_cal_address_control.sv
// Bench for the channel, calibration and address control block.
// Assumes acc_control with default parameters and the serial host model.
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end

module tb_adc_channel_cal_address_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic	clk, rstn, psel, penable, pwrite, pready, pslverr, addr_ack, high_speed_enable;
	logic	scl, bus_read_active, addr_byte_valid, sample_switch, conv_start, conv_done;
	logic	cal_start, cal_done, alert, rerr;
	logic [7:0]	paddr, addr_byte, channel_pin_out, channel_pin_oe, pin_ext;
	logic [31:0]	pwdata, prdata, rd;
	logic [2:0]	strap_level, conv_chan;
	logic [11:0]	conv_code;
	int	err_total, check_count, cycles;
	wire logic [7:0]	channel_pin_in = (channel_pin_oe & channel_pin_out) | (~channel_pin_oe & pin_ext);

	acc_control i_acc_control (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .channel_pin_in, .channel_pin_out, .channel_pin_oe, .scl,
		.bus_read_active, .addr_byte, .addr_byte_valid, .addr_ack, .high_speed_enable,
		.strap_level, .sample_switch, .conv_start, .conv_chan, .conv_done, .conv_code,
		.cal_start, .cal_done, .alert);
	acc_bus_host i_acc_bus_host (.clk, .scl, .bus_read_active, .addr_byte, .addr_byte_valid);

	// ----------------------------------------------------------------
	// Clock, timeout, calibration engine
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			stop_test();
		end
	end

	// Calibration engine ends some cycles after its start pulse
	always @(posedge clk) begin
		if (cal_start === 1'b1) begin
			repeat (12) @(posedge clk);
			cal_done <= 1'b1;
			@(posedge clk) cal_done <= 1'b0;
		end
	end

	task automatic stop_test();
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	// One APB transfer; result in rd and rerr
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		// Waits for the answer; only the bench timeout ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic do_reset(input logic [2:0] s);
		rstn <= 1'b0;
		strap_level <= s;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : do_reset

	task automatic ack_probe(input logic [7:0] b, input logic e);
		i_acc_bus_host.send_addr(b);
		@(posedge clk);
		`CHK(addr_ack, e)
	endtask : ack_probe

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_state();
		apb(1'b0, acc_pkg::OFS_PIN_FUNC, 32'h0);
		`CHK(rd, 32'h0000_0000)
		`CHK(high_speed_enable, 1'b0)
		apb(1'b0, 8'h3C, 32'h0);
		`CHK(rerr, 1'b1)
		`CHK(rd, 32'h0000_0000)
	endtask : t_reset_state

	task automatic t_gpio();
		logic [7:0] lv [2] = '{8'h04, 8'hFB};
		logic [7:0] oe_e, out_e;
		pin_ext <= 8'hAD;
		apb(1'b1, acc_pkg::OFS_DIRECTION, 32'h0F);
		apb(1'b1, acc_pkg::OFS_DRIVER_TYPE, 32'h05);
		apb(1'b1, acc_pkg::OFS_OUT_LEVEL, 32'h0F);
		`CHK(channel_pin_oe, 8'h00)
		apb(1'b1, acc_pkg::OFS_PIN_FUNC, 32'h3C);
		foreach (lv[i]) begin
			apb(1'b1, acc_pkg::OFS_OUT_LEVEL, {24'h0, lv[i]});
			oe_e = 8'h0C & (8'h05 | ~lv[i]);
			out_e = 8'h0C & 8'h05 & lv[i];
			`CHK(channel_pin_oe, oe_e)
			`CHK(channel_pin_out, out_e)
			apb(1'b0, acc_pkg::OFS_READBACK, 32'h0);
			`CHK(rd[7:0], (oe_e & out_e) | (~oe_e & 8'hAD))
		end
	endtask : t_gpio

	task automatic t_convert();
		logic [11:0] codes [3] = '{12'h000, 12'h800, 12'hFFF};
		apb(1'b1, acc_pkg::OFS_CTRL, 32'h0000_0300);
		foreach (codes[i]) begin
			i_acc_bus_host.read_frame(8);
			`CHK(sample_switch, 1'b1)
			i_acc_bus_host.read_frame(9);
			`CHK(sample_switch, 1'b0)
			`CHK(conv_chan, 3'h3)
			conv_code <= codes[i];
			conv_done <= 1'b1;
			@(posedge clk) conv_done <= 1'b0;
			conv_code <= ~codes[i];
			repeat (2) @(posedge clk);
			`CHK(sample_switch, 1'b1)
			apb(1'b0, acc_pkg::OFS_RESULT, 32'h0);
			`CHK(rd[11:0], codes[i])
			`CHK(rd[14:12], 3'h3)
		end
	endtask : t_convert

	task automatic t_cal();
		int n;
		apb(1'b1, acc_pkg::OFS_CTRL, 32'h3);
		apb(1'b0, acc_pkg::OFS_CTRL, 32'h0);
		`CHK(rd[0], 1'b0)
		apb(1'b1, acc_pkg::OFS_CTRL, 32'h0); // Sequencing stopped first
		apb(1'b1, acc_pkg::OFS_CTRL, 32'h1);
		apb(1'b0, acc_pkg::OFS_CTRL, 32'h0);
		`CHK(rd[0], 1'b1)
		n = 0;
		do begin
			apb(1'b0, acc_pkg::OFS_CTRL, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 20);
		`CHK(rd[0], 1'b0)
		apb(1'b1, acc_pkg::OFS_CTRL, 32'h4); // Host enables high speed
		`CHK(high_speed_enable, 1'b1)
	endtask : t_cal

	task automatic t_addr();
		logic [6:0] e;
		for (int i = 0; i < 8; i++) begin
			do_reset(i[2:0]);
			`CHK(channel_pin_oe, 8'h00)
			e = (i < 4) ? 7'h17 - i[6:0] : 7'h0C + i[6:0];
			apb(1'b0, acc_pkg::OFS_TARGET_ADDR, 32'h0);
			`CHK(rd[6:0], e)
			strap_level <= ~i[2:0];
			ack_probe({e, 1'b0}, 1'b1);
			ack_probe({e ^ 7'h01, 1'b0}, 1'b0);
		end
		apb(1'b1, acc_pkg::OFS_TARGET_ADDR, 32'h22);
		ack_probe(8'h44, 1'b1);
	endtask : t_addr

	// Autonomous conversions with no bus frames, thresholds, alert and averaging
	task automatic t_monitor();
		int n;
		apb(1'b1, acc_pkg::OFS_THRESHOLD, 32'h0800_0100);
		apb(1'b1, acc_pkg::OFS_CTRL, 32'h0000_0012); // Autonomous mode, sequencing on
		for (int k = 0; k < 17; k++) begin
			if (k == 16) begin
				apb(1'b1, acc_pkg::OFS_CTRL, 32'h0000_0010); // Stop before the last answer
			end
			n = 0;
			while (sample_switch !== 1'b0 && n < 20) begin
				@(posedge clk);
				n++;
			end
			`CHK(sample_switch, 1'b0)
			conv_code <= k[0] ? 12'h080 : 12'h900;
			conv_done <= 1'b1;
			@(posedge clk) conv_done <= 1'b0;
			repeat (2) @(posedge clk);
		end
		`CHK(sample_switch, 1'b1)
		`CHK(alert, 1'b1)
		apb(1'b0, acc_pkg::OFS_ALERT_FLAGS, 32'h0);
		`CHK(rd[7:0], 8'hFF)
		apb(1'b0, acc_pkg::OFS_RESULT, 32'h0);
		`CHK(rd[31:16], 16'h4C00)
		`CHK(rd[11:0], 12'h900)
		apb(1'b1, acc_pkg::OFS_ALERT_FLAGS, 32'hFF);
		`CHK(alert, 1'b0)
	endtask : t_monitor

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pin_ext = 8'h00;
		strap_level = 3'h2;
		conv_done = 1'b0;
		conv_code = 12'h000;
		cal_done = 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset_state();
		t_gpio();
		t_convert();
		t_cal();
		t_addr();
		t_monitor();
		stop_test();
	end
endmodule : tb_adc_channel_cal_address_control

`default_nettype wire
